// >>> src/ats_hold_timer.sv
`timescale 1ns/1ns
module ats_hold_timer (
  input  wire logic                     i_clk,   // System clock
  input  wire logic                     i_rst,   // Async reset, high
  input  wire logic                     i_tick,  // One-cycle time base pulse
  input  wire logic                     i_cond,  // Condition being qualified
  input  wire logic [ats_pkg::DLY_W-1:0] i_limit, // Delay in ticks
  output logic                          o_done   // Condition held for the delay
);

  typedef struct packed {
    logic [ats_pkg::CNT_W-1:0] cnt;
  } ats_tmr_st_t;

  ats_tmr_st_t q;
  ats_tmr_st_t d;

  always_comb begin
    d = q;
    if (!i_cond) begin
      d.cnt = '0;
    end else if (i_tick && (q.cnt != {ats_pkg::CNT_W{1'b1}})) begin
      d.cnt = q.cnt + 16'h0001;
    end
    o_done = i_cond && (q.cnt >= i_limit);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule // ats_hold_timer

// >>> src/ats_pkg.sv
package ats_pkg;

  // Clock and delay time base
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS       = 1_000_000;
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TICK_W        = 14;

  // Bus and field widths, and input, delay and timer counts
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 32;
  localparam int DLY_W   = 16;
  localparam int CNT_W   = 16;
  localparam int NUM_IN  = 7;
  localparam int NUM_DLY = 5;
  localparam int NUM_TMR = 6;

  // Register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] REG_CTRL          = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATUS        = 8'h04;
  localparam logic [ADDR_W-1:0] REG_OPEN_DELAY    = 8'h08;
  localparam logic [ADDR_W-1:0] REG_START_DELAY   = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_MIN_RUN_DELAY = 8'h10;
  localparam logic [ADDR_W-1:0] REG_RESTORE_DELAY = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STAB_DELAY    = 8'h18;
  localparam logic [ADDR_W-1:0] REG_XFER_COUNT    = 8'h1C;

  // Control register fields
  localparam int CTRL_STRAT2_BIT = 0;
  localparam int CTRL_TEST_BIT   = 1;
  localparam int CTRL_UNLOCK_BIT = 2;

  // Status register fields
  localparam int STAT_STATE_LSB  = 0;
  localparam int STAT_NCB_BIT    = 8;
  localparam int STAT_ECB_BIT    = 9;
  localparam int STAT_GEN_BIT    = 10;
  localparam int STAT_ALARM_BIT  = 11;
  localparam int STAT_DIS_BIT    = 12;
  localparam int STAT_IN_LSB     = 16;

  // Synchronised input positions
  localparam int IN_NORM   = 0;
  localparam int IN_GENPWR = 1;
  localparam int IN_FORCE  = 2;
  localparam int IN_PERMIT = 3;
  localparam int IN_NAUTO  = 4;
  localparam int IN_GALM   = 5;
  localparam int IN_LOCK   = 6;

  // Delay register index
  localparam int DLY_OPEN    = 0;
  localparam int DLY_START   = 1;
  localparam int DLY_MIN_RUN = 2;
  localparam int DLY_RESTORE = 3;
  localparam int DLY_STAB    = 4;

  // Delay reset values in milliseconds
  localparam logic [DLY_W-1:0] RST_OPEN_DELAY    = 16'h01F4;
  localparam logic [DLY_W-1:0] RST_START_DELAY   = 16'h03E8;
  localparam logic [DLY_W-1:0] RST_MIN_RUN_DELAY = 16'h07D0;
  localparam logic [DLY_W-1:0] RST_RESTORE_DELAY = 16'h0BB8;
  localparam logic [DLY_W-1:0] RST_STAB_DELAY    = 16'h03E8;

  // Qualifier timer index
  localparam int TMR_NO_NORM_OPEN  = 0;
  localparam int TMR_NO_NORM_START = 1;
  localparam int TMR_ST2_MIN_RUN   = 2;
  localparam int TMR_NORM_RESTORE  = 3;
  localparam int TMR_ST56_RESTORE  = 4;
  localparam int TMR_GEN_STAB      = 5;

  typedef enum logic [6:0] {
    ST_N_OFF    = 7'h01,
    ST_N_ON     = 7'h02,
    ST_OPEN_OFF = 7'h04,
    ST_OPEN_ON  = 7'h08,
    ST_E_ON     = 7'h10,
    ST_E_OFF    = 7'h20,
    ST_LOCKED   = 7'h40
  } ats_state_t;

  localparam ats_state_t RST_STATE = ST_OPEN_OFF;

  typedef struct packed {
    logic ccd;
    logic permit;
    logic nauto;
    logic galm;
    logic norm;
    logic genpwr;
    logic no_norm_t1;
    logic no_norm_t2;
    logic st2_t3;
    logic norm_t4;
    logic st56_t4;
    logic gen_t5;
  } ats_cond_t;

endpackage

// >>> src/ats_transfer_ctrl.sv
`timescale 1ns/1ns
module ats_transfer_ctrl #(
  parameter int TICK_CYCLES = ats_pkg::TICK_CYCLES
) (
  input  wire logic                      I_REF_CLK,                 // System clock
  input  wire logic                      I_SYS_RST,                 // Async reset, high
  input  wire logic                      I_NORM_POWER_OK,           // Normal line powered
  input  wire logic                      I_GEN_POWER_OK,            // Generator line powered
  input  wire logic                      I_FORCED_TRANSFER_CMD,     // Remote forced transfer
  input  wire logic                      I_TRANSFER_PERMIT,         // Emergency close allowed
  input  wire logic                      I_GENERATOR_NOT_AUTOMATIC, // Generator not in auto
  input  wire logic                      I_GENERATOR_ALARM_IN,      // Generator alarm
  input  wire logic                      I_LOCK_REQ,                // Breaker fault, lock logic
  input  wire logic [ats_pkg::ADDR_W-1:0] I_ADDR,                    // Register address
  input  wire logic [ats_pkg::DATA_W-1:0] I_WDATA,                   // Register write data
  input  wire logic                      I_WR,                      // Write strobe
  input  wire logic                      I_RD,                      // Read strobe
  output logic      [ats_pkg::DATA_W-1:0] O_RDATA,                   // Read data, next cycle
  output logic                           O_NORM_CB_CLOSE,           // Normal breaker closed
  output logic                           O_EMER_CB_CLOSE,           // Emergency breaker closed
  output logic                           O_GEN_RUN,                 // Generator run command
  output logic                           O_ALARM_OUT,               // Alarm contact
  output logic                           O_LOGIC_DISABLED_OUT       // Logic disabled contact
);

  typedef struct packed {
    logic [ats_pkg::NUM_IN-1:0]                  sync1;
    logic [ats_pkg::NUM_IN-1:0]                  sync2;
    ats_pkg::ats_state_t                         state;
    logic                                        strat2;
    logic                                        test;
    logic [ats_pkg::NUM_DLY-1:0][ats_pkg::DLY_W-1:0] dly;
    logic [ats_pkg::TICK_W-1:0]                  presc;
    logic                                        tick;
    logic [ats_pkg::DATA_W-1:0]                  xfer_cnt;
    logic                                        ncb;
    logic                                        ecb;
    logic                                        gen;
    logic                                        alarm;
    logic                                        dis;
    logic [ats_pkg::DATA_W-1:0]                  rdata;
  } ats_top_st_t;

  ats_top_st_t                                   q;
  ats_top_st_t                                   d;
  ats_pkg::ats_cond_t                            cond;
  logic [ats_pkg::NUM_TMR-1:0]                   tmr_cond;
  logic [ats_pkg::NUM_TMR-1:0]                   tmr_done;
  logic [ats_pkg::NUM_TMR-1:0][ats_pkg::DLY_W-1:0] tmr_lim;
  ats_pkg::ats_state_t                           nxt;
  logic                                          unlock;

  // Outputs implied by a state: normal breaker, emergency breaker, generator
  function automatic logic [2:0] state_outputs(input ats_pkg::ats_state_t s);
    logic [2:0] r;
    r = 3'h0;
    unique case (s)
      ats_pkg::ST_N_OFF:    r = 3'b100;
      ats_pkg::ST_N_ON:     r = 3'b101;
      ats_pkg::ST_OPEN_OFF: r = 3'b000;
      ats_pkg::ST_OPEN_ON:  r = 3'b001;
      ats_pkg::ST_E_ON:     r = 3'b011;
      ats_pkg::ST_E_OFF:    r = 3'b010;
      default:              r = 3'b000;
    endcase
    return r;
  endfunction

  // Automatic mode transitions, first matching row wins
  function automatic ats_pkg::ats_state_t auto_next(input ats_pkg::ats_state_t s,
                                                    input logic s2,
                                                    input ats_pkg::ats_cond_t c);
    ats_pkg::ats_state_t r;
    logic ok;
    logic flt;
    r   = s;
    ok  = !c.nauto && !c.galm;
    flt = c.nauto || c.galm;
    unique case (s)
      ats_pkg::ST_N_OFF: begin
        if (ok && (c.ccd || c.no_norm_t2)) begin
          r = ats_pkg::ST_N_ON;
        end else if (!s2 && !c.ccd && c.no_norm_t1) begin
          r = ats_pkg::ST_OPEN_OFF;
        end
      end
      ats_pkg::ST_N_ON: begin
        if ((!c.ccd && ok && c.st2_t3 && c.norm_t4) || flt) begin
          r = ats_pkg::ST_N_OFF;
        end else if (!c.ccd && ok && c.no_norm_t1 && (!s2 || c.gen_t5)) begin
          r = ats_pkg::ST_OPEN_ON;
        end else if (c.ccd && ok && c.gen_t5) begin
          r = ats_pkg::ST_OPEN_ON;
        end
      end
      ats_pkg::ST_OPEN_OFF: begin
        if (c.norm_t4 && (!c.ccd || flt)) begin
          r = ats_pkg::ST_N_OFF;
        end else if (ok && (c.ccd || c.no_norm_t2)) begin
          r = ats_pkg::ST_OPEN_ON;
        end
      end
      ats_pkg::ST_OPEN_ON: begin
        if (!c.ccd && ok && c.norm_t4) begin
          r = ats_pkg::ST_N_ON;
        end else if (flt) begin
          r = ats_pkg::ST_OPEN_OFF;
        end else if (c.permit && ok && c.gen_t5 && (c.ccd || !c.norm)) begin
          r = ats_pkg::ST_E_ON;
        end
      end
      ats_pkg::ST_E_ON: begin
        if (!s2) begin
          if (flt) begin
            r = ats_pkg::ST_OPEN_OFF;
          end else if (ok && c.st56_t4) begin
            r = ats_pkg::ST_OPEN_ON;
          end else if (ok && !c.genpwr) begin
            r = ats_pkg::ST_OPEN_ON;
          end
        end else begin
          if (flt && c.norm_t4) begin
            r = ats_pkg::ST_OPEN_OFF;
          end else if (ok && c.st56_t4 && c.norm_t4 && (!c.ccd || !c.permit)) begin
            r = ats_pkg::ST_OPEN_ON;
          end else if (ok && c.st56_t4 && !c.permit && c.gen_t5) begin
            r = ats_pkg::ST_OPEN_ON;
          end else if (flt) begin
            r = ats_pkg::ST_E_OFF;
          end
        end
      end
      ats_pkg::ST_E_OFF: begin
        if (!s2 || c.norm_t4) begin
          r = ats_pkg::ST_OPEN_OFF;
        end
      end
      ats_pkg::ST_LOCKED: r = s;
      default:            r = ats_pkg::RST_STATE;
    endcase
    return r;
  endfunction

  // Test mode transitions; the alarm column input steers the generator
  function automatic ats_pkg::ats_state_t test_next(input ats_pkg::ats_state_t s,
                                                    input logic s2,
                                                    input ats_pkg::ats_cond_t c);
    ats_pkg::ats_state_t r;
    r = s;
    unique case (s)
      ats_pkg::ST_N_OFF: begin
        if (!c.galm) begin
          r = ats_pkg::ST_N_ON;
        end else if (!s2 && c.no_norm_t1) begin
          r = ats_pkg::ST_OPEN_OFF;
        end
      end
      ats_pkg::ST_N_ON: begin
        if (c.galm) begin
          r = ats_pkg::ST_N_OFF;
        end else if (c.no_norm_t1 && (!s2 || c.gen_t5)) begin
          r = ats_pkg::ST_OPEN_ON;
        end
      end
      ats_pkg::ST_OPEN_OFF: begin
        if (c.norm_t4) begin
          r = ats_pkg::ST_N_OFF;
        end else if (!c.galm) begin
          r = ats_pkg::ST_OPEN_ON;
        end
      end
      ats_pkg::ST_OPEN_ON: begin
        if (!c.galm && c.norm_t4) begin
          r = ats_pkg::ST_N_ON;
        end else if (c.galm) begin
          r = ats_pkg::ST_OPEN_OFF;
        end else if (c.permit && c.gen_t5 && !c.norm) begin
          r = ats_pkg::ST_E_ON;
        end
      end
      ats_pkg::ST_E_ON: begin
        if (!s2) begin
          if (c.galm) begin
            r = ats_pkg::ST_OPEN_OFF;
          end else if (c.st56_t4 && (!c.permit || c.norm_t4)) begin
            r = ats_pkg::ST_OPEN_ON;
          end else if (!c.genpwr) begin
            r = ats_pkg::ST_OPEN_ON;
          end
        end else begin
          if (c.galm && c.norm_t4) begin
            r = ats_pkg::ST_OPEN_OFF;
          end else if (!c.galm && c.st56_t4 && c.norm_t4) begin
            r = ats_pkg::ST_OPEN_ON;
          end else if (!c.galm && !c.permit && c.st56_t4 && c.gen_t5) begin
            r = ats_pkg::ST_OPEN_ON;
          end else if (c.galm) begin
            r = ats_pkg::ST_E_OFF;
          end
        end
      end
      ats_pkg::ST_E_OFF: begin
        if (!s2 || c.norm_t4) begin
          r = ats_pkg::ST_OPEN_OFF;
        end
      end
      ats_pkg::ST_LOCKED: r = s;
      default:            r = ats_pkg::RST_STATE;
    endcase
    return r;
  endfunction

  // Qualifier timers share one millisecond time base
  always_comb begin
    tmr_cond = '0;
    tmr_lim  = '0;
    tmr_cond[ats_pkg::TMR_NO_NORM_OPEN]  = !q.sync2[ats_pkg::IN_NORM];
    tmr_cond[ats_pkg::TMR_NO_NORM_START] = !q.sync2[ats_pkg::IN_NORM];
    tmr_cond[ats_pkg::TMR_ST2_MIN_RUN]   = (q.state == ats_pkg::ST_N_ON);
    tmr_cond[ats_pkg::TMR_NORM_RESTORE]  = q.sync2[ats_pkg::IN_NORM];
    tmr_cond[ats_pkg::TMR_ST56_RESTORE]  = (q.state == ats_pkg::ST_E_ON) ||
                                           (q.state == ats_pkg::ST_E_OFF);
    tmr_cond[ats_pkg::TMR_GEN_STAB]      = q.sync2[ats_pkg::IN_GENPWR];
    tmr_lim[ats_pkg::TMR_NO_NORM_OPEN]   = q.dly[ats_pkg::DLY_OPEN];
    tmr_lim[ats_pkg::TMR_NO_NORM_START]  = q.dly[ats_pkg::DLY_START];
    tmr_lim[ats_pkg::TMR_ST2_MIN_RUN]    = q.dly[ats_pkg::DLY_MIN_RUN];
    tmr_lim[ats_pkg::TMR_NORM_RESTORE]   = q.dly[ats_pkg::DLY_RESTORE];
    tmr_lim[ats_pkg::TMR_ST56_RESTORE]   = q.dly[ats_pkg::DLY_RESTORE];
    tmr_lim[ats_pkg::TMR_GEN_STAB]       = q.dly[ats_pkg::DLY_STAB];
  end

  for (genvar g = 0; g < ats_pkg::NUM_TMR; g++) begin : g_tmr
    ats_hold_timer u_tmr (
      .i_clk   (I_REF_CLK),
      .i_rst   (I_SYS_RST),
      .i_tick  (q.tick),
      .i_cond  (tmr_cond[g]),
      .i_limit (tmr_lim[g]),
      .o_done  (tmr_done[g])
    );
  end

  always_comb begin
    cond            = '0;
    cond.ccd        = q.sync2[ats_pkg::IN_FORCE];
    cond.permit     = q.sync2[ats_pkg::IN_PERMIT];
    cond.nauto      = q.sync2[ats_pkg::IN_NAUTO];
    cond.galm       = q.sync2[ats_pkg::IN_GALM];
    cond.norm       = q.sync2[ats_pkg::IN_NORM];
    cond.genpwr     = q.sync2[ats_pkg::IN_GENPWR];
    cond.no_norm_t1 = tmr_done[ats_pkg::TMR_NO_NORM_OPEN];
    cond.no_norm_t2 = tmr_done[ats_pkg::TMR_NO_NORM_START];
    cond.st2_t3     = tmr_done[ats_pkg::TMR_ST2_MIN_RUN];
    cond.norm_t4    = tmr_done[ats_pkg::TMR_NORM_RESTORE];
    cond.st56_t4    = tmr_done[ats_pkg::TMR_ST56_RESTORE];
    cond.gen_t5     = tmr_done[ats_pkg::TMR_GEN_STAB];
    if (q.test) begin
      nxt = test_next(q.state, q.strat2, cond);
    end else begin
      nxt = auto_next(q.state, q.strat2, cond);
    end
  end

  always_comb begin
    logic [2:0] outs;
    outs   = 3'h0;
    d      = q;
    unlock = I_WR && (I_ADDR == ats_pkg::REG_CTRL) && I_WDATA[ats_pkg::CTRL_UNLOCK_BIT];
    d.sync1 = {I_LOCK_REQ, I_GENERATOR_ALARM_IN, I_GENERATOR_NOT_AUTOMATIC,
               I_TRANSFER_PERMIT, I_FORCED_TRANSFER_CMD, I_GEN_POWER_OK, I_NORM_POWER_OK};
    d.sync2 = q.sync1;
    // Time base for all delays
    d.tick = 1'b0;
    if (q.presc >= TICK_W_CAST(TICK_CYCLES - 1)) begin
      d.presc = '0;
      d.tick  = 1'b1;
    end else begin
      d.presc = q.presc + 14'h0001;
    end
    // State update; lock overrides everything and is left only by unlock
    if (q.sync2[ats_pkg::IN_LOCK]) begin
      d.state = ats_pkg::ST_LOCKED;
    end else if (q.state == ats_pkg::ST_LOCKED) begin
      if (unlock) begin
        d.state = ats_pkg::RST_STATE;
      end
    end else begin
      d.state = nxt;
    end
    if ((d.state != q.state) && (d.state != ats_pkg::ST_LOCKED)) begin
      d.xfer_cnt = q.xfer_cnt + 32'h0000_0001;
    end
    // Breakers and generator hold while locked
    if (d.state != ats_pkg::ST_LOCKED) begin
      outs  = state_outputs(d.state);
      d.ncb = outs[2];
      d.ecb = outs[1];
      d.gen = outs[0];
    end
    d.dis   = (d.state == ats_pkg::ST_LOCKED);
    d.alarm = (d.state == ats_pkg::ST_LOCKED) ||
              (q.sync2[ats_pkg::IN_GALM] && !q.test);
    // Register writes
    if (I_WR) begin
      unique case (I_ADDR)
        ats_pkg::REG_CTRL: begin
          d.strat2 = I_WDATA[ats_pkg::CTRL_STRAT2_BIT];
          d.test   = I_WDATA[ats_pkg::CTRL_TEST_BIT];
        end
        ats_pkg::REG_OPEN_DELAY:    d.dly[ats_pkg::DLY_OPEN]    = I_WDATA[ats_pkg::DLY_W-1:0];
        ats_pkg::REG_START_DELAY:   d.dly[ats_pkg::DLY_START]   = I_WDATA[ats_pkg::DLY_W-1:0];
        ats_pkg::REG_MIN_RUN_DELAY: d.dly[ats_pkg::DLY_MIN_RUN] = I_WDATA[ats_pkg::DLY_W-1:0];
        ats_pkg::REG_RESTORE_DELAY: d.dly[ats_pkg::DLY_RESTORE] = I_WDATA[ats_pkg::DLY_W-1:0];
        ats_pkg::REG_STAB_DELAY:    d.dly[ats_pkg::DLY_STAB]    = I_WDATA[ats_pkg::DLY_W-1:0];
        default: ;
      endcase
    end
    // Read data stands for exactly one cycle
    d.rdata = '0;
    if (I_RD) begin
      unique case (I_ADDR)
        ats_pkg::REG_CTRL: begin
          d.rdata[ats_pkg::CTRL_STRAT2_BIT] = q.strat2;
          d.rdata[ats_pkg::CTRL_TEST_BIT]   = q.test;
        end
        ats_pkg::REG_STATUS: begin
          d.rdata[ats_pkg::STAT_STATE_LSB +: 7]          = q.state;
          d.rdata[ats_pkg::STAT_NCB_BIT]                 = q.ncb;
          d.rdata[ats_pkg::STAT_ECB_BIT]                 = q.ecb;
          d.rdata[ats_pkg::STAT_GEN_BIT]                 = q.gen;
          d.rdata[ats_pkg::STAT_ALARM_BIT]               = q.alarm;
          d.rdata[ats_pkg::STAT_DIS_BIT]                 = q.dis;
          d.rdata[ats_pkg::STAT_IN_LSB +: ats_pkg::NUM_IN] = q.sync2;
        end
        ats_pkg::REG_OPEN_DELAY:    d.rdata[ats_pkg::DLY_W-1:0] = q.dly[ats_pkg::DLY_OPEN];
        ats_pkg::REG_START_DELAY:   d.rdata[ats_pkg::DLY_W-1:0] = q.dly[ats_pkg::DLY_START];
        ats_pkg::REG_MIN_RUN_DELAY: d.rdata[ats_pkg::DLY_W-1:0] = q.dly[ats_pkg::DLY_MIN_RUN];
        ats_pkg::REG_RESTORE_DELAY: d.rdata[ats_pkg::DLY_W-1:0] = q.dly[ats_pkg::DLY_RESTORE];
        ats_pkg::REG_STAB_DELAY:    d.rdata[ats_pkg::DLY_W-1:0] = q.dly[ats_pkg::DLY_STAB];
        ats_pkg::REG_XFER_COUNT:    d.rdata = q.xfer_cnt;
        default: ;
      endcase
    end
  end

  function automatic logic [ats_pkg::TICK_W-1:0] TICK_W_CAST(input int v);
    return ats_pkg::TICK_W'(v);
  endfunction

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      q                          <= '0;
      q.state                    <= ats_pkg::RST_STATE;
      q.dly[ats_pkg::DLY_OPEN]    <= ats_pkg::RST_OPEN_DELAY;
      q.dly[ats_pkg::DLY_START]   <= ats_pkg::RST_START_DELAY;
      q.dly[ats_pkg::DLY_MIN_RUN] <= ats_pkg::RST_MIN_RUN_DELAY;
      q.dly[ats_pkg::DLY_RESTORE] <= ats_pkg::RST_RESTORE_DELAY;
      q.dly[ats_pkg::DLY_STAB]    <= ats_pkg::RST_STAB_DELAY;
    end else begin
      q <= d;
    end
  end

  assign O_RDATA              = q.rdata;
  assign O_NORM_CB_CLOSE      = q.ncb;
  assign O_EMER_CB_CLOSE      = q.ecb;
  assign O_GEN_RUN            = q.gen;
  assign O_ALARM_OUT          = q.alarm;
  assign O_LOGIC_DISABLED_OUT = q.dis;

endmodule // ats_transfer_ctrl

// >>> tb/ats_checker.sv
`timescale 1ns/1ns
module ats_checker (
  input wire logic        I_REF_CLK,                 // Clock
  input wire logic        I_SYS_RST,                 // Reset
  input wire logic        I_FORCED_TRANSFER_CMD,     // Force
  input wire logic        I_GENERATOR_NOT_AUTOMATIC, // Not auto
  input wire logic        I_GENERATOR_ALARM_IN,      // Gen alarm
  input wire logic        I_LOCK_REQ,                // Lock
  input wire logic [7:0]  I_ADDR,                    // Address
  input wire logic [31:0] I_WDATA,                   // Write data
  input wire logic        I_WR,                      // Write
  input wire logic        O_NORM_CB_CLOSE,           // Normal CB
  input wire logic        O_EMER_CB_CLOSE,           // Emergency CB
  input wire logic        O_GEN_RUN,                 // Gen run
  input wire logic        O_ALARM_OUT,               // Alarm
  input wire logic        O_LOGIC_DISABLED_OUT       // Disabled
);
  logic test_q;
  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) test_q <= 1'b0;
    else if (I_WR && I_ADDR == ats_pkg::REG_CTRL) test_q <= I_WDATA[ats_pkg::CTRL_TEST_BIT];
  end
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);
  a_cb_exclusive: assert property (!(O_NORM_CB_CLOSE && O_EMER_CB_CLOSE))
    else $error("both breakers closed");
  a_lock_alarm: assert property (O_LOGIC_DISABLED_OUT |-> O_ALARM_OUT)
    else $error("locked without alarm");
  a_lock_freeze: assert property (O_LOGIC_DISABLED_OUT && $past(O_LOGIC_DISABLED_OUT) |->
    $stable(O_NORM_CB_CLOSE) && $stable(O_EMER_CB_CLOSE) && $stable(O_GEN_RUN))
    else $error("outputs moved while locked");
  a_lock_entry: assert property ($rose(I_LOCK_REQ) |-> ##[2:4] O_LOGIC_DISABLED_OUT)
    else $error("lock not entered");
  a_emer_entry: assert property ($rose(O_EMER_CB_CLOSE) |->
    $past(O_GEN_RUN) && !$past(O_NORM_CB_CLOSE)) else $error("bad emergency close");
  a_force_start: assert property ($rose(I_FORCED_TRANSFER_CMD) && O_NORM_CB_CLOSE &&
    !test_q && !O_GEN_RUN && !I_GENERATOR_NOT_AUTOMATIC && !I_GENERATOR_ALARM_IN && !I_LOCK_REQ &&
    !O_LOGIC_DISABLED_OUT |-> ##[2:4] O_GEN_RUN) else $error("forced start missing");
  a_fault_stop: assert property ($rose(I_GENERATOR_NOT_AUTOMATIC) && !test_q &&
    O_NORM_CB_CLOSE && O_GEN_RUN && !O_LOGIC_DISABLED_OUT && !I_LOCK_REQ |->
    ##[2:4] O_NORM_CB_CLOSE && !O_GEN_RUN) else $error("generator kept on fault");
  a_test_gen: assert property ($rose(I_GENERATOR_ALARM_IN) && test_q &&
    O_NORM_CB_CLOSE && O_GEN_RUN && !O_LOGIC_DISABLED_OUT && !I_LOCK_REQ |->
    ##[2:4] O_NORM_CB_CLOSE && !O_GEN_RUN) else $error("test stop missing");
endmodule // ats_checker
bind ats_transfer_ctrl ats_checker ats_checker_i (.I_REF_CLK, .I_SYS_RST, .I_FORCED_TRANSFER_CMD,
  .I_GENERATOR_NOT_AUTOMATIC, .I_GENERATOR_ALARM_IN, .I_LOCK_REQ, .I_ADDR, .I_WDATA, .I_WR,
  .O_NORM_CB_CLOSE, .O_EMER_CB_CLOSE, .O_GEN_RUN, .O_ALARM_OUT, .O_LOGIC_DISABLED_OUT);

// >>> tb/ats_gen_model.sv
`timescale 1ns/1ns
module ats_gen_model (
  input  wire logic i_clk, // Clock
  input  wire logic i_run, // Start command
  output logic      o_pwr  // Generator line powered
);
  logic [3:0] cnt_q = 4'h0;
  // Power comes up some cycles after start, drops at once on stop
  always_ff @(posedge i_clk) cnt_q <= i_run ? cnt_q + {3'b000, cnt_q != 4'hF} : 4'h0;
  assign o_pwr = cnt_q > 4'h5;
endmodule // ats_gen_model

// >>> tb/ats_transfer_ctrl_tb.sv
`timescale 1ns/1ns
module ats_transfer_ctrl_tb;
  logic clk = 0, rst = 1, norm = 1, frc = 0, permit = 1, nauto = 0, galm = 0, lock = 0;
  logic wr = 0, rd = 0, ncb, ecb, gen, alm, dis, gpwr;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  int bad_count = 0, compares = 0, cyc = 0;
  logic [7:0] ra [6] = '{8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h40};
  logic [31:0] rv [6] = '{32'h0000_01F4, 32'h0000_03E8, 32'h0000_07D0, 32'h0000_0BB8,
                          32'h0000_03E8, 32'h0000_0000};
  ats_transfer_ctrl #(.TICK_CYCLES(4)) ats_transfer_ctrl_i (.I_REF_CLK(clk), .I_SYS_RST(rst),
    .I_NORM_POWER_OK(norm), .I_GEN_POWER_OK(gpwr), .I_FORCED_TRANSFER_CMD(frc),
    .I_TRANSFER_PERMIT(permit), .I_GENERATOR_NOT_AUTOMATIC(nauto), .I_GENERATOR_ALARM_IN(galm),
    .I_LOCK_REQ(lock), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .O_NORM_CB_CLOSE(ncb), .O_EMER_CB_CLOSE(ecb), .O_GEN_RUN(gen), .O_ALARM_OUT(alm),
    .O_LOGIC_DISABLED_OUT(dis));
  ats_gen_model ats_gen_model_i (.i_clk(clk), .i_run(gen), .o_pwr(gpwr));
  initial forever #50 clk = ~clk;
  task close_out();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1; end
    @(posedge clk) wr <= 0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk) begin addr <= a; rd <= 1; end
    @(posedge clk) rd <= 0;
    @(negedge clk) chk("rdata", rdata, e);
  endtask
  // Waits a bounded time for the breaker and generator outputs to reach a state
  task wait_out(input logic [2:0] e);
    int i;
    @(negedge clk);
    for (i = 0; i < 300 && {ncb, ecb, gen} !== e; i++) @(negedge clk);
    chk("cb_gen", 32'({ncb, ecb, gen}), 32'(e));
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 0;
    @(negedge clk) chk("reset_outs", 32'({ncb, ecb, gen, alm, dis}), 32'h0000_0000);
    for (int i = 0; i < 6; i++) rd_chk(ra[i], rv[i]);
    for (int i = 0; i < 5; i++) wr_reg(8'h08 + 8'(4 * i), i == 1 ? 32'h0000_0002 : 32'h0000_0003);
    wait_out(3'b100);
    rd_chk(8'h04, 32'h0009_0101);
    rd_chk(8'h1C, 32'h0000_0001);
    @(posedge clk) norm <= 0;
    wait_out(3'b101);
    wait_out(3'b001);
    wait_out(3'b011);
    @(posedge clk) norm <= 1;
    wait_out(3'b001);
    wait_out(3'b101);
    wait_out(3'b100);
    @(posedge clk) frc <= 1;
    wait_out(3'b101);
    @(posedge clk) nauto <= 1;
    wait_out(3'b100);
    @(posedge clk) nauto <= 0;
    wait_out(3'b001);
    wait_out(3'b011);
    @(posedge clk) frc <= 0;
    wait_out(3'b100);
    wr_reg(8'h00, 32'h0000_0001);
    rd_chk(8'h00, 32'h0000_0001);
    @(posedge clk) norm <= 0;
    wait_out(3'b011);
    @(posedge clk) galm <= 1;
    wait_out(3'b010);
    chk("gen_alarm_out", 32'(alm), 32'h0000_0001);
    @(posedge clk) norm <= 1;
    wait_out(3'b000);
    wait_out(3'b100);
    wr_reg(8'h00, 32'h0000_0002);
    @(posedge clk) nauto <= 1;
    @(posedge clk) galm <= 0;
    wait_out(3'b101);
    @(posedge clk) galm <= 1;
    wait_out(3'b100);
    chk("test_alarm_out", 32'(alm), 32'h0000_0000);
    wr_reg(8'h00, 32'h0000_0000);
    @(posedge clk) begin nauto <= 0; galm <= 0; lock <= 1; end
    repeat (5) @(negedge clk);
    chk("lock_flags", 32'({alm, dis, ncb}), 32'h0000_0007);
    wr_reg(8'h00, 32'h0000_0004);
    repeat (3) @(negedge clk);
    chk("still_locked", 32'(dis), 32'h0000_0001);
    @(posedge clk) lock <= 0;
    repeat (3) @(posedge clk);
    wr_reg(8'h00, 32'h0000_0004);
    wait_out(3'b000);
    chk("unlocked", 32'(dis), 32'h0000_0000);
    close_out();
  end
endmodule // ats_transfer_ctrl_tb
